// ===== clock_power_pkg.sv
// Purpose: constants, types and carriers for the clock and power-mode block
// Assumes: one 20 MHz clock, APB register access, 32-bit data
// Notes: register offsets are byte addresses
package clock_power_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IRQEN = 8'h04;
    localparam logic [7:0] OFS_FLAG = 8'h08;
    localparam logic [7:0] OFS_PBCFG = 8'h0C;
    localparam logic [7:0] OFS_EXTCFG = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_CMD = 8'h18;
    // Flag positions
    localparam int FL_WDT = 0;
    localparam int FL_PB = 1;
    localparam int FL_EXT = 2;
    localparam int FL_LVD = 3;
    localparam int FL_T0 = 4;
    localparam int FL_T1 = 5;
    localparam logic [5:0] HALT_WAKE_MASK = 6'h07;
    localparam logic [1:0] OPM_RUN = 2'h0;
    localparam logic [1:0] OPM_HALT = 2'h1;
    localparam logic [1:0] OPM_STANDBY = 2'h2;
    // Command bits
    localparam int CMD_SLEEP = 0;
    localparam int CMD_ENI = 1;
    localparam int CMD_IRQ_DISABLE_INSTRUCTION = 2;
    localparam int CMD_CLRWDT = 3;
    localparam logic [9:0] IRQ_VECTOR = 10'h008;
    localparam logic [9:0] WAKE_XTAL = 10'h200;
    localparam logic [9:0] WAKE_RC = 10'h010;
    localparam logic TO_RESET = 1'b1;
    localparam logic PD_RESET = 1'b1;
    typedef enum logic [1:0] {HOSC_IRC, HOSC_HXT, HOSC_XT} fastKind_t;
    typedef enum logic {LOSC_IRC, LOSC_LXT} slowKind_t;
    typedef enum {M_START, M_RUN, M_STANDBY, M_HALT, M_WAKE} mode_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apbReq_t;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apbRsp_t;
    typedef struct packed {
        logic startupFast;
        fastKind_t fastKind;
        slowKind_t slowKind;
        logic instDiv4;
        logic [2:0] hrcFreqSel;
        logic clkOutPin4;
        logic wdtIrqMode;
        logic timer0SrcSlow;
    } cfg_t;
    typedef struct packed {
        logic fastOscEn;
        logic slowOscEn;
        logic sysClkFast;
        logic instTick;
        logic coreRun;
        logic periphEn;
        logic wdtClear;
        logic irqBranch;
        logic [9:0] irqVector;
        logic pin4Xout;
        logic pin5Xin;
        logic pin4ClkOut;
        logic [4:0] hrcFreqMhz;
        logic timer0ClkSlow;
    } ctrlOut_t;
endpackage : clock_power_pkg

// ===== clock_power_ctrl.sv
// Purpose: dual oscillator selection, instruction clock and power modes
// Assumes: oscillator ready, port and low-voltage inputs are asynchronous
// Notes: system clock is modelled by clk; instTick marks instruction cycles
`timescale 1ns/1ns
module clock_power_ctrl
(
    input wire logic clk,
    input wire logic nrst,
    input wire clock_power_pkg::apbReq_t apbReq,
    output clock_power_pkg::apbRsp_t apbRsp,
    input wire clock_power_pkg::cfg_t cfg,
    input wire logic fastOscReady,
    input wire logic slowOscReady,
    input wire logic [7:0] pbPins,
    input wire logic lvdLevel,
    input wire logic wdtTimeout,
    input wire logic t0Overflow,
    input wire logic t1Underflow,
    output clock_power_pkg::ctrlOut_t ctrl
);
    import clock_power_pkg::*;

    typedef struct packed {
        mode_t mode;
        logic highOsc;
        logic fastStop;
        logic [1:0] opMode;
        logic lowClkT0;
        logic global_irq_enable;
        logic [5:0] irqEn;
        logic [5:0] flag;
        logic [7:0] pbWake;
        logic [7:0] pbInput;
        logic extSel;
        logic extPol;
        logic toStat;
        logic pdStat;
        logic useFast;
        logic [9:0] wakeCnt;
        logic [1:0] divCnt;
        logic [7:0] pbMeta;
        logic [7:0] pbSync;
        logic [7:0] pbPrev;
        logic lvdMeta;
        logic lvdSync;
        logic lvdPrev;
        logic fRdyMeta;
        logic fRdy;
        logic sRdyMeta;
        logic sRdy;
        apbRsp_t rsp;
        ctrlOut_t out;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [5:0] setEv;
    logic [7:0] pbChg;
    logic crystal;
    logic wrEn;
    logic mapped;
    logic [31:0] rdVal;
    logic [5:0] flagClr;
    logic [9:0] wakeLen;

    assign apbRsp = st_r.rsp;
    assign ctrl = st_r.out;

    // Fast RC frequency code to MHz
    function automatic logic [4:0] hrcMhz(input logic [2:0] sel);
        logic [4:0] f;
        f = 5'h01;
        case (sel)
            3'h0: f = 5'h01;
            3'h1: f = 5'h02;
            3'h2: f = 5'h04;
            3'h3: f = 5'h08;
            3'h4: f = 5'h10;
            3'h5: f = 5'h14;
            default: f = 5'h01;
        endcase
        return f;
    endfunction : hrcMhz

    // Event detection on synchronised pin and low-voltage inputs and raw timer events
    always_comb
    begin
        crystal = (cfg.fastKind != HOSC_IRC) || (cfg.slowKind == LOSC_LXT);
        pbChg = (st_r.pbSync ^ st_r.pbPrev) & st_r.pbWake & st_r.pbInput;
        if (st_r.extSel)
        begin
            pbChg[0] = 1'b0;
        end
        setEv = 6'h00;
        setEv[FL_WDT] = wdtTimeout && cfg.wdtIrqMode;
        setEv[FL_PB] = |pbChg;
        setEv[FL_EXT] = st_r.extSel && (st_r.pbSync[0] != st_r.pbPrev[0])
            && (st_r.pbSync[0] == st_r.extPol);
        setEv[FL_LVD] = st_r.lvdPrev && !st_r.lvdSync;
        // Timer events are masked while in halt, so they cannot set their flags there
        setEv[FL_T0] = t0Overflow && (st_r.mode != M_HALT);
        setEv[FL_T1] = t1Underflow && (st_r.mode != M_HALT);
    end

    // Register decode and read mux
    always_comb
    begin
        wrEn = apbReq.psel && apbReq.penable && apbReq.pwrite
            && st_r.rsp.pready;
        mapped = 1'b1;
        rdVal = 32'h0000_0000;
        case (apbReq.paddr)
            OFS_CTRL: rdVal = {26'h0, st_r.global_irq_enable, st_r.lowClkT0,
                st_r.opMode, st_r.fastStop, st_r.highOsc};
            OFS_IRQEN: rdVal = {26'h0, st_r.irqEn};
            OFS_FLAG: rdVal = {26'h0, st_r.flag};
            OFS_PBCFG: rdVal = {16'h0, st_r.pbInput, st_r.pbWake};
            OFS_EXTCFG: rdVal = {30'h0, st_r.extPol, st_r.extSel};
            OFS_STATUS: rdVal = {24'h0, st_r.lvdSync, st_r.useFast,
                st_r.fRdy, st_r.mode == M_STANDBY, st_r.mode == M_HALT,
                !st_r.useFast, st_r.pdStat, st_r.toStat};
            OFS_CMD: rdVal = 32'h0000_0000;
            default: mapped = 1'b0;
        endcase
        flagClr = 6'h00;
        if (wrEn && apbReq.paddr == OFS_FLAG)
        begin
            flagClr = ~apbReq.pwdata[5:0];
        end
    end

    // Next state
    always_comb
    begin
        st_nxt = st_r;
        // Two-flop synchronisers
        st_nxt.pbMeta = pbPins;
        st_nxt.pbSync = st_r.pbMeta;
        st_nxt.pbPrev = st_r.pbSync;
        st_nxt.lvdMeta = lvdLevel;
        st_nxt.lvdSync = st_r.lvdMeta;
        st_nxt.lvdPrev = st_r.lvdSync;
        st_nxt.fRdyMeta = fastOscReady;
        st_nxt.fRdy = st_r.fRdyMeta;
        st_nxt.sRdyMeta = slowOscReady;
        st_nxt.sRdy = st_r.sRdyMeta;
        // APB answer: zero wait, decided in the setup cycle
        st_nxt.rsp.pready = apbReq.psel && !apbReq.penable;
        st_nxt.rsp.pslverr = apbReq.psel && !apbReq.penable && !mapped;
        st_nxt.rsp.prdata = (apbReq.psel && !apbReq.penable)
            ? rdVal : 32'h0000_0000;
        st_nxt.out.wdtClear = 1'b0;
        st_nxt.out.irqBranch = 1'b0;
        // Register writes
        if (wrEn)
        begin
            case (apbReq.paddr)
                OFS_CTRL:
                begin
                    st_nxt.highOsc = apbReq.pwdata[0];
                    st_nxt.fastStop = apbReq.pwdata[1];
                    st_nxt.opMode = apbReq.pwdata[3:2];
                    st_nxt.lowClkT0 = apbReq.pwdata[4];
                    st_nxt.global_irq_enable = apbReq.pwdata[5];
                end
                OFS_IRQEN: st_nxt.irqEn = apbReq.pwdata[5:0];
                OFS_PBCFG:
                begin
                    st_nxt.pbWake = apbReq.pwdata[7:0];
                    st_nxt.pbInput = apbReq.pwdata[15:8];
                end
                OFS_EXTCFG:
                begin
                    st_nxt.extSel = apbReq.pwdata[0];
                    st_nxt.extPol = apbReq.pwdata[1];
                end
                OFS_CMD:
                begin
                    if (apbReq.pwdata[CMD_ENI])
                    begin
                        st_nxt.global_irq_enable = 1'b1;
                    end
                    if (apbReq.pwdata[CMD_IRQ_DISABLE_INSTRUCTION])
                    begin
                        st_nxt.global_irq_enable = 1'b0;
                    end
                    if (apbReq.pwdata[CMD_CLRWDT])
                    begin
                        st_nxt.toStat = 1'b1;
                        st_nxt.pdStat = 1'b1;
                        st_nxt.out.wdtClear = 1'b1;
                    end
                    if (apbReq.pwdata[CMD_SLEEP])
                    begin
                        st_nxt.opMode = OPM_HALT;
                    end
                end
                default: st_nxt.flag = st_r.flag;
            endcase
        end
        // Flags: a set in the clearing cycle wins
        st_nxt.flag = (st_r.flag & ~flagClr) | setEv;
        // Mode sequencing
        case (st_r.mode)
            M_START:
            begin
                st_nxt.highOsc = cfg.startupFast;
                st_nxt.useFast = cfg.startupFast;
                st_nxt.mode = M_RUN;
            end
            M_RUN:
            begin
                // Change over only once the target source runs
                if (st_r.highOsc && !st_r.useFast && st_r.fRdy)
                begin
                    st_nxt.useFast = 1'b1;
                end
                else if (!st_r.highOsc && st_r.useFast && st_r.sRdy)
                begin
                    st_nxt.useFast = 1'b0;
                end
                if (st_r.global_irq_enable && |(st_r.flag & st_r.irqEn))
                begin
                    st_nxt.out.irqBranch = 1'b1;
                    st_nxt.global_irq_enable = 1'b0;
                end
                else if (st_r.opMode == OPM_STANDBY)
                begin
                    st_nxt.mode = M_STANDBY;
                end
                else if (st_r.opMode == OPM_HALT)
                begin
                    // Stop bit in the same write is fine here
                    st_nxt.mode = M_HALT;
                    st_nxt.pdStat = 1'b0;
                    st_nxt.toStat = 1'b1;
                    st_nxt.out.wdtClear = 1'b1;
                end
            end
            M_STANDBY:
            begin
                // Standby stops neither oscillator (fast only by fastStop), so no settling wait
                if (|(setEv & st_r.irqEn))
                begin
                    st_nxt.mode = M_RUN;
                    st_nxt.opMode = OPM_RUN;
                end
            end
            M_HALT:
            begin
                if (|(setEv & st_r.irqEn & HALT_WAKE_MASK))
                begin
                    st_nxt.mode = M_WAKE;
                    st_nxt.wakeCnt = crystal ? WAKE_XTAL - 10'h001
                        : WAKE_RC - 10'h001;
                end
            end
            M_WAKE:
            begin
                if (st_r.wakeCnt == 10'h000)
                begin
                    st_nxt.mode = M_RUN;
                    st_nxt.opMode = OPM_RUN;
                end
                else
                begin
                    st_nxt.wakeCnt = st_r.wakeCnt - 10'h001;
                end
            end
            default: st_nxt.mode = M_START;
        endcase
        // Watchdog expiry always clears the timeout status
        if (wdtTimeout)
        begin
            st_nxt.toStat = 1'b0;
        end
        // Instruction clock divider, running only while executing
        if (st_nxt.mode == M_RUN)
        begin
            if (st_r.divCnt == (cfg.instDiv4 ? 2'h3 : 2'h1))
            begin
                st_nxt.divCnt = 2'h0;
            end
            else
            begin
                st_nxt.divCnt = st_r.divCnt + 2'h1;
            end
        end
        else
        begin
            st_nxt.divCnt = 2'h0;
        end
        st_nxt.out.instTick = (st_nxt.mode == M_RUN)
            && (st_r.divCnt == (cfg.instDiv4 ? 2'h3 : 2'h1));
        // Oscillator, pin and peripheral controls
        st_nxt.out.fastOscEn = !st_nxt.fastStop
            && (st_nxt.mode != M_HALT);
        st_nxt.out.slowOscEn = (st_nxt.mode != M_HALT);
        st_nxt.out.sysClkFast = st_nxt.useFast;
        st_nxt.out.coreRun = (st_nxt.mode == M_RUN);
        st_nxt.out.periphEn = (st_nxt.mode != M_HALT);
        st_nxt.out.irqVector = IRQ_VECTOR;
        st_nxt.out.pin4Xout = crystal;
        st_nxt.out.pin5Xin = crystal;
        st_nxt.out.pin4ClkOut = !crystal && cfg.clkOutPin4;
        st_nxt.out.hrcFreqMhz = (cfg.fastKind == HOSC_IRC)
            ? hrcMhz(cfg.hrcFreqSel) : 5'h00;
        st_nxt.out.timer0ClkSlow = st_nxt.lowClkT0 && cfg.timer0SrcSlow
            && st_nxt.useFast && (st_nxt.mode != M_HALT);
    end

    // State register, synchronous reset
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_r <= '0;
            st_r.mode <= M_START;
            st_r.toStat <= TO_RESET;
            st_r.pdStat <= PD_RESET;
            st_r.highOsc <= 1'b1;
            st_r.useFast <= 1'b1;
            st_r.out.slowOscEn <= 1'b1;
            st_r.out.fastOscEn <= 1'b1;
            st_r.out.periphEn <= 1'b1;
            st_r.out.sysClkFast <= 1'b1;
            st_r.out.irqVector <= IRQ_VECTOR;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Helper: cycles spent in the wake wait
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            wakeLen <= 10'h000;
        end
        else if (st_r.mode == M_WAKE)
        begin
            wakeLen <= wakeLen + 10'h001;
        end
        else
        begin
            wakeLen <= 10'h000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_wdt_flag_set: assert property (wdtTimeout && cfg.wdtIrqMode
        |=> st_r.flag[FL_WDT])
        else $error("watchdog flag not set");
    a_pb0_masked: assert property (st_r.extSel
        && pbChg[7:1] == 7'h00 |-> !setEv[FL_PB])
        else $error("pin0 change seen under external select");
    a_lvd_fall: assert property ($fell(st_r.lvdSync)
        |=> st_r.flag[FL_LVD])
        else $error("low-voltage flag missed");
    a_sysclk_follows: assert property (st_r.mode == M_RUN
        && st_r.highOsc && !st_r.useFast && st_r.fRdy
        |=> st_r.useFast && st_r.out.sysClkFast)
        else $error("clock select wrong");
    a_inst_div_four: assert property (st_r.out.instTick
        && cfg.instDiv4 && st_r.mode == M_RUN |=> !st_r.out.instTick [*3])
        else $error("instruction tick spacing wrong");
    a_halt_entry: assert property ($rose(st_r.mode == M_HALT)
        && !$past(wdtTimeout) |-> !st_r.pdStat && st_r.toStat
        && st_r.out.wdtClear)
        else $error("halt entry status wrong");
    a_halt_osc_off: assert property (st_r.mode == M_HALT
        |-> !st_r.out.fastOscEn && !st_r.out.slowOscEn
        && !st_r.out.periphEn)
        else $error("oscillator running in halt");
    a_standby_wake: assert property (st_r.mode == M_STANDBY
        && |(setEv & st_r.irqEn) |=> st_r.mode == M_RUN)
        else $error("standby did not wake at once");
    a_wake_length: assert property ($fell(st_r.mode == M_WAKE)
        |-> $past(wakeLen) == (crystal ? WAKE_XTAL : WAKE_RC)
        - 10'h001)
        else $error("wake wait length wrong");
    a_gie_branch: assert property (st_r.mode == M_RUN && st_r.global_irq_enable
        && |(st_r.flag & st_r.irqEn) |=> st_r.out.irqBranch
        && !st_r.global_irq_enable)
        else $error("interrupt branch missing");
endmodule : clock_power_ctrl

// ===== osc_model.sv
// Purpose: far-side model of the fast and slow oscillators
// Assumes: start-up time counted in controller clock cycles
// Notes: ready drops at the next clock edge after an oscillator is disabled
`timescale 1ns/1ns
module osc_model
#(
    parameter int START_CYCLES = 6
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic fastOscEn,
    input wire logic slowOscEn,
    output logic fastOscReady,
    output logic slowOscReady
);
    int fastCnt = 0;
    int slowCnt = 0;
    // Stopped oscillator loses ready; a restart waits the full start-up
    always @(posedge clk)
    begin
        if (!nrst || !fastOscEn)
            fastCnt <= 0;
        else if (fastCnt < START_CYCLES)
            fastCnt <= fastCnt + 1;
        if (!nrst || !slowOscEn)
            slowCnt <= 0;
        else if (slowCnt < START_CYCLES)
            slowCnt <= slowCnt + 1;
    end
    // Ready levels seen by the controller
    assign fastOscReady = (fastCnt == START_CYCLES);
    assign slowOscReady = (slowCnt == START_CYCLES);
endmodule : osc_model

// ===== dual_clock_power_mode_ctrl_tb_top.sv
// Purpose: self-checking bench for the clock and power-mode block
// Assumes: zero-wait APB slave, oscillator model on the far side
// Notes: pins and crystal kind drawn from a fixed seed
`timescale 1ns/1ns
module dual_clock_power_mode_ctrl_tb_top;
    import clock_power_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    apbReq_t apbReq = '0;
    apbRsp_t apbRsp;
    cfg_t cfg = '{startupFast: 1'b1, fastKind: HOSC_IRC, slowKind: LOSC_IRC,
        instDiv4: 1'b0, hrcFreqSel: 3'h0, clkOutPin4: 1'b1,
        wdtIrqMode: 1'b1, timer0SrcSlow: 1'b1};
    logic fastOscReady;
    logic slowOscReady;
    logic [7:0] pbPins = 8'h00;
    logic lvdLevel = 1'b1;
    logic wdtTimeout = 1'b0;
    logic t0Overflow = 1'b0;
    logic t1Underflow = 1'b0;
    ctrlOut_t ctrl;
    int n_mismatch = 0;
    int checks = 0;
    int nBranch = 0;
    int n;
    int p;
    logic sawClr = 1'b0;
    logic [31:0] q;
    logic e;

    always #25 clk = ~clk;

    // Catch one-cycle pulses so later checks need not hit the exact cycle
    always @(posedge clk)
    begin
        if (ctrl.wdtClear === 1'b1)
            sawClr <= 1'b1;
        if (ctrl.irqBranch === 1'b1)
            nBranch <= nBranch + 1;
    end

    clock_power_ctrl clock_power_ctrl_inst (.clk(clk), .nrst(nrst),
        .apbReq(apbReq), .apbRsp(apbRsp), .cfg(cfg),
        .fastOscReady(fastOscReady), .slowOscReady(slowOscReady),
        .pbPins(pbPins), .lvdLevel(lvdLevel), .wdtTimeout(wdtTimeout),
        .t0Overflow(t0Overflow), .t1Underflow(t1Underflow), .ctrl(ctrl));
    osc_model osc_model_inst (.clk(clk), .nrst(nrst),
        .fastOscEn(ctrl.fastOscEn), .slowOscEn(ctrl.slowOscEn),
        .fastOscReady(fastOscReady), .slowOscReady(slowOscReady));

    task automatic complete_run();
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic timeout(input string what);
        n_mismatch++;
        $display("CHECK FAILED %s expected response seen none", what);
        complete_run();
    endtask : timeout

    // Request held from setup until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
            pwdata: d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (apbRsp.pready !== 1'b1 && k < 16);
        if (apbRsp.pready !== 1'b1)
            timeout("pready");
        q = apbRsp.prdata;
        e = apbRsp.pslverr;
        apbReq <= '0;
    endtask : apb

    // Wait for coreRun (sel 0) or sysClkFast (sel 1) to reach lvl
    task automatic waitSig(input logic lvl, input logic sel, input int lim,
        output int k);
        k = 0;
        while ((sel ? ctrl.sysClkFast : ctrl.coreRun) !== lvl && k < lim)
        begin
            @(negedge clk);
            k++;
        end
        if ((sel ? ctrl.sysClkFast : ctrl.coreRun) !== lvl)
            timeout("mode change");
    endtask : waitSig

    task automatic pulse(input int k);
        @(posedge clk);
        if (k == 0)
            wdtTimeout <= 1'b1;
        else if (k == 1)
            t0Overflow <= 1'b1;
        else
            t1Underflow <= 1'b1;
        @(posedge clk);
        wdtTimeout <= 1'b0;
        t0Overflow <= 1'b0;
        t1Underflow <= 1'b0;
    endtask : pulse

    // Let an event settle through sync, then read and clear flags
    task automatic expectFlag(input string what, input logic [5:0] exp);
        repeat (6) @(posedge clk);
        apb(1'b0, OFS_FLAG, 32'h0000_0000);
        chk(what, {26'h0, exp}, q);
        apb(1'b1, OFS_FLAG, 32'h0000_0000);
    endtask : expectFlag

    function automatic logic [31:0] hrcMhz(input int sel);
        int t[6] = '{1, 2, 4, 8, 16, 20};
        return t[sel];
    endfunction : hrcMhz

    function automatic int wakeWait(input fastKind_t f, input slowKind_t s);
        return (f != HOSC_IRC || s == LOSC_LXT) ? 512 : 16;
    endfunction : wakeWait

    // Halt with global enable set, stray timer event, wake on pin pin;
    // viaCmd enters through the sleep and enable commands instead
    task automatic haltCycle(input int pin, input logic viaCmd);
        int w;
        int k;
        w = wakeWait(cfg.fastKind, cfg.slowKind);
        sawClr = 1'b0;
        nBranch = 0;
        apb(1'b1, OFS_IRQEN, 32'h0000_0012);
        if (viaCmd)
        begin
            apb(1'b1, OFS_CTRL, 32'h0000_0001);
            apb(1'b1, OFS_CMD, 32'h0000_0003);
        end
        else
            apb(1'b1, OFS_CTRL, 32'h0000_0025);
        repeat (2) @(negedge clk);
        chk("haltOsc", 32'h0, {30'h0, ctrl.fastOscEn, ctrl.slowOscEn});
        chk("haltCore", 32'h0, {30'h0, ctrl.periphEn, ctrl.coreRun});
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("haltStatus", 32'h0000_0009, q & 32'h0000_000B);
        chk("wdtClear", 32'h1, {31'h0, sawClr});
        pulse(1);
        repeat (8) @(negedge clk);
        chk("haltTimer", 32'h0, {31'h0, ctrl.coreRun});
        @(posedge clk);
        pbPins[pin] <= ~pbPins[pin];
        waitSig(1'b1, 1'b0, w + 40, k);
        chk("wakeWait", 32'h1, {31'h0, k >= w && k <= w + 12});
        repeat (3) @(negedge clk);
        chk("wakeBranch", 32'h1, nBranch);
        chk("wakeFast", 32'h1, {31'h0, ctrl.sysClkFast});
        chk("vector", 32'h8, {22'h0, ctrl.irqVector});
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk("ctrlAfter", 32'h1, q & 32'h0000_002D);
        apb(1'b1, OFS_FLAG, 32'h0000_0000);
    endtask : haltCycle

    initial
    begin
        void'($urandom(32'h7a69));
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        waitSig(1'b1, 1'b0, 8, n);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("startStatus", 32'h0000_0043, q & 32'h0000_0047);
        apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
        chk("badWrErr", 32'h1, {31'h0, e});
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk("badRd", 32'h1, {q[30:0], e});
        // Instruction ticks at half, then a quarter of the clock rate
        for (int d = 0; d < 2; d++)
        begin
            @(posedge clk);
            cfg.instDiv4 <= d[0];
            repeat (4) @(negedge clk);
            n = 0;
            repeat (40)
            begin
                @(negedge clk);
                if (ctrl.instTick === 1'b1)
                    n++;
            end
            chk("ticks", (d != 0) ? 32'd10 : 32'd20, n);
        end
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            cfg.hrcFreqSel <= i[2:0];
            repeat (3) @(negedge clk);
            chk("hrcMhz", hrcMhz(i), {27'h0, ctrl.hrcFreqMhz});
        end
        chk("rcPins", 32'h1, {29'h0, ctrl.pin4Xout, ctrl.pin5Xin,
            ctrl.pin4ClkOut});
        apb(1'b1, OFS_CTRL, 32'h0000_0011);
        repeat (2) @(negedge clk);
        chk("t0Slow", 32'h1, {31'h0, ctrl.timer0ClkSlow});
        // Flag sources with global enable off
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        apb(1'b1, OFS_PBCFG, 32'h0000_FFFF);
        apb(1'b1, OFS_EXTCFG, 32'h0000_0003);
        pulse(0);
        expectFlag("wdtFlag", 6'h01);
        p = $urandom_range(7, 1);
        pbPins[p] <= ~pbPins[p];
        expectFlag("pbFlag", 6'h02);
        pbPins[0] <= 1'b1;
        expectFlag("extRise", 6'h04);
        pbPins[0] <= 1'b0;
        expectFlag("extFall", 6'h00);
        lvdLevel <= 1'b0;
        expectFlag("lvdFlag", 6'h08);
        // Slow mode first, then stop fast, then standby
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        waitSig(1'b0, 1'b1, 40, n);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("slowMode", 32'h4, q & 32'h0000_0044);
        chk("fastKept", 32'h1, {31'h0, ctrl.fastOscEn});
        apb(1'b1, OFS_CTRL, 32'h0000_0002);
        repeat (2) @(negedge clk);
        chk("fastStop", 32'h1, {30'h0, ctrl.fastOscEn, ctrl.slowOscEn});
        apb(1'b1, OFS_IRQEN, 32'h0000_0030);
        nBranch = 0;
        apb(1'b1, OFS_CTRL, 32'h0000_000A);
        waitSig(1'b0, 1'b0, 4, n);
        chk("sbySlow", 32'h1, {31'h0, ctrl.slowOscEn});
        pulse($urandom_range(2, 1));
        waitSig(1'b1, 1'b0, 8, n);
        chk("sbyResume", 32'h0, {31'h0, ctrl.sysClkFast});
        chk("sbyNoBranch", 32'h0, nBranch);
        apb(1'b1, OFS_FLAG, 32'h0000_0000);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        waitSig(1'b1, 1'b1, 40, n);
        haltCycle($urandom_range(7, 1), 1'b0);
        // Crystal on the fast side claims pins 4 and 5
        @(posedge clk);
        cfg.fastKind <= ($urandom_range(1, 0) != 0) ? HOSC_HXT : HOSC_XT;
        repeat (3) @(negedge clk);
        chk("xtalPins", 32'h6, {29'h0, ctrl.pin4Xout, ctrl.pin5Xin,
            ctrl.pin4ClkOut});
        chk("xtalMhz", 32'h0, {27'h0, ctrl.hrcFreqMhz});
        haltCycle($urandom_range(7, 1), 1'b1);
        // Command word: enable, then disable plus watchdog clear
        apb(1'b1, OFS_CMD, 32'h0000_0002);
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk("eniGie", 32'h20, q & 32'h0000_0020);
        sawClr = 1'b0;
        apb(1'b1, OFS_CMD, 32'h0000_000C);
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk("disiGie", 32'h0, q & 32'h0000_0020);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("clrwdtStat", 32'h3, q & 32'h0000_0003);
        chk("clrwdtPulse", 32'h1, {31'h0, sawClr});
        complete_run();
    end
endmodule : dual_clock_power_mode_ctrl_tb_top
